// *** design/pcd_pkg.sv ***
// shared constants and types for the port C/D pin function and direction block
package pcd_pkg;
	// register byte offsets on the Wishbone slave
	localparam logic [7:0]  OFS_PC_FS2     = 8'h00;
	localparam logic [7:0]  OFS_PD_DIR_HI  = 8'h04;
	localparam logic [7:0]  OFS_PD_DIR_LO  = 8'h08;
	localparam logic [7:0]  OFS_PD_FS1     = 8'h0C;
	localparam logic [7:0]  OFS_PD_FS2     = 8'h10;

	localparam int          REG_W          = 16;
	localparam int          FIELD_W        = 2;
	localparam int          PC_PINS        = 8;
	localparam int          PD_HALF        = 16;
	localparam int          PHASE_PIN_IDX  = 7;

	localparam logic [15:0] REG_RESET      = 16'h0000;
	localparam logic [15:0] UPPER_ZERO     = 16'h0000;
	localparam logic [15:0] PC_FS2_WMASK   = 16'h5555;
	localparam logic [31:0] OE_N_IDLE      = 32'hFFFFFFFF;
	localparam logic [15:0] DEF_SCK_MASK   = 16'h2000;
	localparam logic [15:0] DEF_TIMER_MASK = 16'hF800;

	// two-bit port D high field codes
	localparam logic [1:0]  FN_GPIO        = 2'b00;
	localparam logic [1:0]  FN_DATA        = 2'b01;
	localparam logic [1:0]  FN_PERIPH      = 2'b10;
	localparam logic [1:0]  FN_TIMER       = 2'b11;

	typedef enum logic [1:0] {
		MODE_SINGLE  = 2'b00,
		MODE_ROM_OFF = 2'b01,
		MODE_ROM_ON  = 2'b10
	} pcd_mode_t;
endpackage : pcd_pkg

// *** design/pcd_wb_if.sv ***
// classic Wishbone handshake: one wait state, then ack for one cycle
`timescale 1ns/1ps
`default_nettype none
module pcd_wb_if (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic cyc,
	input  wire logic stb,
	input  wire logic we,
	output logic      ack,
	output logic      wr_pulse,
	output logic      rd_take
);
	logic ack_q;
	logic ack_d;
	logic req_w;

	assign req_w    = cyc & stb;
	// ack drops after one cycle so a held request is not answered on two edges in a row
	assign ack_d    = req_w & ~ack_q;
	assign ack      = ack_q;
	// write lands on the edge at which the master sees ack
	assign wr_pulse = req_w & we & ack_q;
	assign rd_take  = req_w & ~we & ~ack_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
		end
	end
endmodule : pcd_wb_if
`default_nettype wire

// *** design/pcd_portc_mux.sv ***
// per-pin port C output mux between general I/O and address output
`timescale 1ns/1ps
`default_nettype none
module pcd_portc_mux #(
	parameter int PINS = 8
) (
	input  wire logic            clk,
	input  wire logic            nrst,
	input  wire logic [PINS-1:0] addr_sel,
	input  wire logic [PINS-1:0] bus_addr,
	input  wire logic [PINS-1:0] gpio_out,
	input  wire logic [PINS-1:0] gpio_dir,
	output logic      [PINS-1:0] pin_out,
	output logic      [PINS-1:0] pin_oe_n
);
	logic [PINS-1:0] out_d;
	logic [PINS-1:0] oe_n_d;

	if (PINS < 1) begin : g_chk
		$error("pcd_portc_mux: PINS must be at least 1");
	end

	for (genvar i = 0; i < PINS; i++) begin : g_pin
		assign out_d[i]  = addr_sel[i] ? bus_addr[i] : gpio_out[i];
		// address pins always drive, whatever the direction setting
		assign oe_n_d[i] = addr_sel[i] ? 1'b0 : ~gpio_dir[i];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out  <= out_d;
			pin_oe_n <= oe_n_d;
		end
	end
endmodule : pcd_portc_mux
`default_nettype wire

// *** design/pcd_port_cd.sv ***
// port C low and port D function select and direction registers with pin decode
// How it works
// - odd bits of port C function register read zero; software writes zero there.
// - even bits 14..0 pick port C pins 7..0: 0 general I/O, 1 address.
// - single-chip mode keeps port C pins general I/O even with select 1.
// - ROM-disabled modes drive address on port C pins even with select 0.
// - port C function register clears only on power-on reset.
// - high direction bits 15..0 set pins 31..16: 1 output, 0 input.
// - high direction acts only for general I/O, serial clock, timer or pin 23 phase.
// - high direction register clears only on power-on reset.
// - low direction bits 15..0 set pins 15..0: 1 output, 0 input.
// - low direction acts only for general I/O or timer pins.
// - low direction register clears only on power-on reset.
// - high function register 1 covers pins 31..24, register 2 pins 23..16.
// - both port D function registers are 16-bit read/write, power-on reset only.
// - data-bus selection on port D high takes effect only in modes allowing it.
// - field 00 I/O, 01 data bus, 10 peripheral, 11 timer or reserved.
`timescale 1ns/1ps
`default_nettype none
module pcd_port_cd #(
	parameter int          ADDR_W     = 8,
	parameter logic [15:0] SCK_MASK   = pcd_pkg::DEF_SCK_MASK,
	parameter logic [15:0] TIMER_MASK = pcd_pkg::DEF_TIMER_MASK,
	parameter logic [1:0]  PHASE_CODE = pcd_pkg::FN_PERIPH
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [ADDR_W-1:0]     wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire pcd_pkg::pcd_mode_t    op_mode,
	input  wire logic                  cs0_bus32,
	input  wire logic [7:0]            bus_addr,
	input  wire logic [7:0]            portc_gpio_out,
	input  wire logic [7:0]            portc_gpio_dir,
	output logic      [7:0]            portc_pin_out,
	output logic      [7:0]            portc_pin_oe_n,
	output logic      [7:0]            portc_addr_sel,
	input  wire logic [15:0]           portd_lo_func_ok,
	output logic      [31:0]           portd_dir_ctrl,
	output logic      [31:0]           portd_dir_oe_n,
	output logic      [15:0]           portd_hi_gpio_sel,
	output logic      [15:0]           portd_hi_data_sel,
	output logic      [15:0]           portd_hi_periph_sel,
	output logic      [15:0]           portd_hi_timer_sel
);
	localparam int PD_W = 2 * pcd_pkg::PD_HALF;

	if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
		$error("pcd_port_cd: ADDR_W must lie in 5..32");
	end

	// register state; only nrst, the power-on reset, clears it
	logic [15:0] pc_fs2_q;
	logic [15:0] pc_fs2_d;
	logic [15:0] dir_hi_q;
	logic [15:0] dir_hi_d;
	logic [15:0] dir_lo_q;
	logic [15:0] dir_lo_d;
	logic [15:0] pd_fs1_q;
	logic [15:0] pd_fs1_d;
	logic [15:0] pd_fs2_q;
	logic [15:0] pd_fs2_d;
	logic [15:0] rdat_q;

	logic        wr_pulse;
	logic        rd_take;
	logic        hit_pc;
	logic        hit_dh;
	logic        hit_dl;
	logic        hit_f1;
	logic        hit_f2;
	logic [15:0] rd_mux;
	logic [15:0] wr_merge_pc;
	logic [15:0] wr_merge_dh;
	logic [15:0] wr_merge_dl;
	logic [15:0] wr_merge_f1;
	logic [15:0] wr_merge_f2;

	logic        mode_single;
	logic        mode_rom_off;
	logic        mode_rom_on;
	logic        data_ok;
	logic [7:0]  pc_addr_sel_w;
	logic [31:0] hi_fields;
	logic [15:0] hi_gpio_w;
	logic [15:0] hi_data_w;
	logic [15:0] hi_periph_w;
	logic [15:0] hi_timer_w;
	logic [15:0] hi_ctrl_w;
	logic [31:0] dir_ctrl_w;
	logic [31:0] dir_oe_n_w;

	function automatic logic [15:0] lane_merge(
		input logic [15:0] old,
		input logic [31:0] wdat,
		input logic [3:0]  sel
	);
		lane_merge = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
	endfunction : lane_merge

	pcd_wb_if u_wb (
		.clk      (clk),
		.nrst     (nrst),
		.cyc      (wb_cyc_i),
		.stb      (wb_stb_i),
		.we       (wb_we_i),
		.ack      (wb_ack_o),
		.wr_pulse (wr_pulse),
		.rd_take  (rd_take)
	);

	// address decode; unmapped words read zero and ignore writes
	assign hit_pc = wb_adr_i == ADDR_W'(pcd_pkg::OFS_PC_FS2);
	assign hit_dh = wb_adr_i == ADDR_W'(pcd_pkg::OFS_PD_DIR_HI);
	assign hit_dl = wb_adr_i == ADDR_W'(pcd_pkg::OFS_PD_DIR_LO);
	assign hit_f1 = wb_adr_i == ADDR_W'(pcd_pkg::OFS_PD_FS1);
	assign hit_f2 = wb_adr_i == ADDR_W'(pcd_pkg::OFS_PD_FS2);

	assign rd_mux = hit_pc ? pc_fs2_q :
	                hit_dh ? dir_hi_q :
	                hit_dl ? dir_lo_q :
	                hit_f1 ? pd_fs1_q :
	                hit_f2 ? pd_fs2_q : pcd_pkg::REG_RESET;

	assign wr_merge_pc = lane_merge(pc_fs2_q, wb_dat_i, wb_sel_i);
	assign wr_merge_dh = lane_merge(dir_hi_q, wb_dat_i, wb_sel_i);
	assign wr_merge_dl = lane_merge(dir_lo_q, wb_dat_i, wb_sel_i);
	assign wr_merge_f1 = lane_merge(pd_fs1_q, wb_dat_i, wb_sel_i);
	assign wr_merge_f2 = lane_merge(pd_fs2_q, wb_dat_i, wb_sel_i);

	// reserved odd bits are dropped on write, so they always read back zero
	assign pc_fs2_d = (wr_pulse && hit_pc) ? (wr_merge_pc & pcd_pkg::PC_FS2_WMASK) : pc_fs2_q;
	assign dir_hi_d = (wr_pulse && hit_dh) ? wr_merge_dh : dir_hi_q;
	assign dir_lo_d = (wr_pulse && hit_dl) ? wr_merge_dl : dir_lo_q;
	assign pd_fs1_d = (wr_pulse && hit_f1) ? wr_merge_f1 : pd_fs1_q;
	assign pd_fs2_d = (wr_pulse && hit_f2) ? wr_merge_f2 : pd_fs2_q;

	// no watchdog, standby or sleep input reaches these flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_fs2_q <= pcd_pkg::REG_RESET;
			dir_hi_q <= pcd_pkg::REG_RESET;
			dir_lo_q <= pcd_pkg::REG_RESET;
			pd_fs1_q <= pcd_pkg::REG_RESET;
			pd_fs2_q <= pcd_pkg::REG_RESET;
		end else begin
			pc_fs2_q <= pc_fs2_d;
			dir_hi_q <= dir_hi_d;
			dir_lo_q <= dir_lo_d;
			pd_fs1_q <= pd_fs1_d;
			pd_fs2_q <= pd_fs2_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdat_q <= pcd_pkg::REG_RESET;
		end else if (rd_take) begin
			rdat_q <= rd_mux;
		end
	end

	assign wb_dat_o = {pcd_pkg::UPPER_ZERO, rdat_q};

	// operating mode; the unused code 11 behaves as single-chip
	assign mode_single  = op_mode == pcd_pkg::MODE_SINGLE;
	assign mode_rom_off = op_mode == pcd_pkg::MODE_ROM_OFF;
	assign mode_rom_on  = op_mode == pcd_pkg::MODE_ROM_ON;

	// port C: mode overrides the select bit in both directions
	for (genvar i = 0; i < pcd_pkg::PC_PINS; i++) begin : g_pc
		assign pc_addr_sel_w[i] = mode_rom_off |
		                          (mode_rom_on & pc_fs2_q[2*i]);
	end

	pcd_portc_mux #(
		.PINS (pcd_pkg::PC_PINS)
	) u_pc (
		.clk      (clk),
		.nrst     (nrst),
		.addr_sel (pc_addr_sel_w),
		.bus_addr (bus_addr),
		.gpio_out (portc_gpio_out),
		.gpio_dir (portc_gpio_dir),
		.pin_out  (portc_pin_out),
		.pin_oe_n (portc_pin_oe_n)
	);

	// register 1 above register 2 lines up pin 16+i with field i
	assign hi_fields = {pd_fs1_q, pd_fs2_q};
	// data lines need an external-bus mode with a 32-bit CS0 space
	assign data_ok   = ~mode_single & (mode_rom_off | mode_rom_on) & cs0_bus32;

	for (genvar i = 0; i < pcd_pkg::PD_HALF; i++) begin : g_pdh
		logic [1:0] code;
		assign code = hi_fields[pcd_pkg::FIELD_W*i +: pcd_pkg::FIELD_W];
		// ROM-off boot with a wide bus turns general I/O into data lines too
		assign hi_data_w[i]   = data_ok & ((code == pcd_pkg::FN_DATA) |
		                        ((code == pcd_pkg::FN_GPIO) & mode_rom_off));
		assign hi_gpio_w[i]   = ((code == pcd_pkg::FN_GPIO) | (code == pcd_pkg::FN_DATA)) & ~hi_data_w[i];
		assign hi_periph_w[i] = code == pcd_pkg::FN_PERIPH;
		// code 11 is reserved on pins without a timer pin; it selects nothing
		assign hi_timer_w[i]  = (code == pcd_pkg::FN_TIMER) & TIMER_MASK[i];
		assign hi_ctrl_w[i]   = hi_gpio_w[i] | hi_timer_w[i] |
		                        (hi_periph_w[i] & SCK_MASK[i]) |
		                        ((i == pcd_pkg::PHASE_PIN_IDX) && (code == PHASE_CODE));
	end

	assign dir_ctrl_w = {hi_ctrl_w, portd_lo_func_ok};
	assign dir_oe_n_w = ~(dir_ctrl_w & {dir_hi_q, dir_lo_q});

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			portc_addr_sel      <= '0;
			portd_dir_ctrl      <= '0;
			portd_dir_oe_n      <= pcd_pkg::OE_N_IDLE;
			portd_hi_gpio_sel   <= '0;
			portd_hi_data_sel   <= '0;
			portd_hi_periph_sel <= '0;
			portd_hi_timer_sel  <= '0;
		end else begin
			portc_addr_sel      <= pc_addr_sel_w;
			portd_dir_ctrl      <= dir_ctrl_w;
			portd_dir_oe_n      <= dir_oe_n_w;
			portd_hi_gpio_sel   <= hi_gpio_w;
			portd_hi_data_sel   <= hi_data_w;
			portd_hi_periph_sel <= hi_periph_w;
			portd_hi_timer_sel  <= hi_timer_w;
		end
	end

	a_pc_resv_zero: assert property (@(posedge clk) disable iff (!nrst)
		(pc_fs2_q & ~pcd_pkg::PC_FS2_WMASK) == pcd_pkg::REG_RESET)
		else $error("reserved port C select bit is set");

	a_pc_select_map: assert property (@(posedge clk) disable iff (!nrst)
		mode_rom_on |-> pc_addr_sel_w == {pc_fs2_q[14], pc_fs2_q[12], pc_fs2_q[10], pc_fs2_q[8],
		                                  pc_fs2_q[6], pc_fs2_q[4], pc_fs2_q[2], pc_fs2_q[0]})
		else $error("port C select does not follow the even bits");

	a_pc_single_gpio: assert property (@(posedge clk) disable iff (!nrst)
		mode_single ##1 mode_single |-> portc_addr_sel == 8'h00)
		else $error("port C drives address in single-chip mode");

	a_pc_romoff_addr: assert property (@(posedge clk) disable iff (!nrst)
		mode_rom_off |=> portc_addr_sel == 8'hFF && portc_pin_oe_n == 8'h00)
		else $error("port C not on address in ROM-disabled mode");

	a_pc_addr_drive: assert property (@(posedge clk) disable iff (!nrst)
		pc_addr_sel_w[0] |=> !portc_pin_oe_n[0] && portc_pin_out[0] == $past(bus_addr[0]))
		else $error("address pin not driven from bus address");

	a_regs_hold: assert property (@(posedge clk) disable iff (!nrst)
		!wr_pulse |=> $stable({pc_fs2_q, dir_hi_q, dir_lo_q, pd_fs1_q, pd_fs2_q}))
		else $error("register changed without a bus write");

	a_dir_hi_apply: assert property (@(posedge clk) disable iff (!nrst)
		1'b1 |=> portd_dir_oe_n[31:16] == ~($past(hi_ctrl_w) & $past(dir_hi_q)))
		else $error("port D high direction not applied");

	a_dir_lo_apply: assert property (@(posedge clk) disable iff (!nrst)
		!portd_lo_func_ok[0] |=> portd_dir_oe_n[0] && portd_dir_ctrl[0] == 1'b0)
		else $error("port D low direction acts on a foreign function");

	a_fs1_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_pulse && hit_f1 && wb_sel_i[1:0] == 2'b11 |=> pd_fs1_q == $past(wb_dat_i[15:0]))
		else $error("port D function register 1 write lost");

	a_data_gate: assert property (@(posedge clk) disable iff (!nrst)
		(mode_single || !cs0_bus32) |-> hi_data_w == 16'h0000)
		else $error("data line selected in a mode that forbids it");

	a_pin31_periph: assert property (@(posedge clk) disable iff (!nrst)
		pd_fs1_q[15:14] == pcd_pkg::FN_PERIPH |=> portd_hi_periph_sel[15])
		else $error("pin 31 peripheral code not decoded");

	a_ack_single: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_ack_answer: assert property (@(posedge clk) disable iff (!nrst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered after one wait state");

	a_rd_capture: assert property (@(posedge clk) disable iff (!nrst)
		rd_take |=> wb_dat_o == {pcd_pkg::UPPER_ZERO, $past(rd_mux)})
		else $error("read data not captured when the read was taken");

	a_pc_fs_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_pulse && hit_pc && wb_sel_i[1:0] == 2'b11 |=> pc_fs2_q == ($past(wb_dat_i[15:0]) & pcd_pkg::PC_FS2_WMASK))
		else $error("port C function register write lost");

	a_dir_hi_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_pulse && hit_dh && wb_sel_i[1:0] == 2'b11 |=> dir_hi_q == $past(wb_dat_i[15:0]))
		else $error("port D high direction write lost");

	a_dir_lo_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_pulse && hit_dl && wb_sel_i[1:0] == 2'b11 |=> dir_lo_q == $past(wb_dat_i[15:0]))
		else $error("port D low direction write lost");

	a_fs2_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_pulse && hit_f2 && wb_sel_i[1:0] == 2'b11 |=> pd_fs2_q == $past(wb_dat_i[15:0]))
		else $error("port D function register 2 write lost");

	a_pc_gpio_path: assert property (@(posedge clk) disable iff (!nrst)
		!pc_addr_sel_w[0] |=> portc_pin_out[0] == $past(portc_gpio_out[0]) &&
		                      portc_pin_oe_n[0] == !$past(portc_gpio_dir[0]))
		else $error("general I/O pin not driven from the I/O source");

	a_dir_lo_out: assert property (@(posedge clk) disable iff (!nrst)
		portd_lo_func_ok[0] && dir_lo_q[0] |=> !portd_dir_oe_n[0] && portd_dir_ctrl[0])
		else $error("port D low direction output not applied");

	a_sck_ctrl: assert property (@(posedge clk) disable iff (!nrst)
		pd_fs1_q[11:10] == pcd_pkg::FN_PERIPH |=> portd_dir_ctrl[29] == SCK_MASK[13])
		else $error("serial clock pin direction control wrong");

	a_pin16_timer: assert property (@(posedge clk) disable iff (!nrst)
		pd_fs2_q[1:0] == pcd_pkg::FN_TIMER |=> portd_hi_timer_sel[0] == TIMER_MASK[0] && !portd_hi_periph_sel[0])
		else $error("pin 16 timer code decoded wrongly");

	c_pc_addr_write: cover property (@(posedge clk) disable iff (!nrst)
		wr_pulse && hit_pc ##1 mode_rom_on && pc_addr_sel_w != 8'h00);

	c_pd_output: cover property (@(posedge clk) disable iff (!nrst)
		portd_dir_oe_n[31:16] != 16'hFFFF);

	c_data_line: cover property (@(posedge clk) disable iff (!nrst)
		hi_data_w != 16'h0000);

	c_read_back: cover property (@(posedge clk) disable iff (!nrst)
		rd_take && hit_dl ##1 wb_ack_o);

	c_single_override: cover property (@(posedge clk) disable iff (!nrst)
		mode_single && pc_fs2_q != 16'h0000);
endmodule : pcd_port_cd
`default_nettype wire

// *** sim/pcd_pin_model.sv ***
// pin-side partner: bus controller address, port C general I/O sources and port D low function-ok flags
`timescale 1ns/1ps
`default_nettype none
module pcd_pin_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        step,
	output logic      [7:0]  bus_addr,
	output logic      [7:0]  gpio_out,
	output logic      [7:0]  gpio_dir,
	output logic      [15:0] lo_func_ok
);
	logic [31:0] st_q;
	// values move only on step, so the registered pin path can settle before a compare
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_q <= 32'h0000004A;
		else if (step)
			st_q <= st_q * 32'h0019660D + 32'h3C6EF35F;
	end
	assign bus_addr   = st_q[31:24];
	assign gpio_out   = st_q[23:16];
	assign gpio_dir   = st_q[15:8];
	assign lo_func_ok = {st_q[7:0], st_q[27:20]};
endmodule : pcd_pin_model
`default_nettype wire

// *** sim/test_port_cd_pin_function_direction.sv ***
// self-checking bench: register model and pin decode model against the block
`timescale 1ns/1ps
`default_nettype none
module test_port_cd_pin_function_direction;
	logic               clk  = 1'b0;
	logic               nrst = 1'b0;
	logic               cyc  = 1'b0;
	logic               stb  = 1'b0;
	logic               we   = 1'b0;
	logic               cs32 = 1'b0;
	logic               step = 1'b0;
	logic [7:0]         adr  = 8'h00;
	logic [3:0]         sel  = 4'h0;
	logic [31:0]        wdat = 32'h00000000;
	pcd_pkg::pcd_mode_t mode = pcd_pkg::MODE_SINGLE;
	wire logic [31:0]   rdat, dctl, doe;
	wire logic          ack;
	wire logic [7:0]    ba, go, gd, pco, pcoe, asel_o;
	wire logic [15:0]   lok, gs, ds, ps, ts;
	logic [15:0]        m [5];
	logic [15:0]        lf = 16'h004A;
	int                 n_errors = 0;
	int                 total_checks = 0;
	int                 cyc_cnt = 0;

	always #20 clk = ~clk;

	pcd_pin_model pins (.clk(clk), .nrst(nrst), .step(step), .bus_addr(ba), .gpio_out(go),
		.gpio_dir(gd), .lo_func_ok(lok));

	pcd_port_cd uut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.op_mode(mode), .cs0_bus32(cs32), .bus_addr(ba), .portc_gpio_out(go),
		.portc_gpio_dir(gd), .portc_pin_out(pco), .portc_pin_oe_n(pcoe),
		.portc_addr_sel(asel_o), .portd_lo_func_ok(lok), .portd_dir_ctrl(dctl),
		.portd_dir_oe_n(doe), .portd_hi_gpio_sel(gs), .portd_hi_data_sel(ds),
		.portd_hi_periph_sel(ps), .portd_hi_timer_sel(ts));

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	task automatic test_done();
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one classic cycle; ack and read data are taken at the rising edge, before its own updates land
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic reg_wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [31:0] q;
		int          k;
		if (a == 8'h00)
			d = d & 32'h00005555;
		wb(1'b1, a, s, d, q);
		k = a >> 2;
		if (a[1:0] == 2'b00 && k < 5) begin
			if (s[0])
				m[k][7:0] = d[7:0];
			if (s[1])
				m[k][15:8] = d[15:8];
		end
		m[0] = m[0] & 16'h5555;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a);
		logic [31:0] q;
		int          k;
		wb(1'b0, a, 4'hF, 32'h00000000, q);
		k = a >> 2;
		chk("rdata", (a[1:0] == 2'b00 && k < 5) ? {16'h0000, m[k]} : 32'h00000000, q);
	endtask : reg_rd

	task automatic check_pins();
		logic [7:0]  as;
		logic [15:0] g, d, p, t;
		logic [31:0] f, ct;
		logic [1:0]  c;
		for (int i = 0; i < 8; i++)
			as[i] = m[0][2*i];
		if (mode == pcd_pkg::MODE_ROM_OFF)
			as = 8'hFF;
		else if (mode != pcd_pkg::MODE_ROM_ON)
			as = 8'h00;
		f = {m[3], m[4]};
		for (int i = 0; i < 16; i++) begin
			c = f[2*i +: 2];
			d[i] = cs32 && ((c == 2'b01 && mode inside {pcd_pkg::MODE_ROM_OFF, pcd_pkg::MODE_ROM_ON})
				|| (c == 2'b00 && mode == pcd_pkg::MODE_ROM_OFF));
			g[i] = !d[i] && !c[1];
			p[i] = (c == 2'b10);
			t[i] = (c == 2'b11) && (i >= 11);
			ct[16+i] = g[i] | (p[i] & (i == 13)) | t[i] | (p[i] & (i == 7));
		end
		ct[15:0] = lok;
		chk("addr_sel", {24'h0, as}, {24'h0, asel_o});
		chk("pc_out", {24'h0, (as & ba) | (~as & go)}, {24'h0, pco});
		chk("pc_oe_n", {24'h0, ~as & ~gd}, {24'h0, pcoe});
		chk("dir_ctrl", ct, dctl);
		chk("dir_oe_n", ~(ct & {m[1], m[2]}), doe);
		chk("hi_sel_a", {g, d}, {gs, ds});
		chk("hi_sel_b", {p, t}, {ps, ts});
	endtask : check_pins

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			test_done();
		end
	end

	initial begin
		for (int k = 0; k < 5; k++)
			m[k] = 16'h0000;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int a = 0; a <= 20; a += 4)
			reg_rd(a[7:0]);
		for (int it = 0; it < 240; it++) begin
			lf = lfsr(lf);
			mode <= pcd_pkg::pcd_mode_t'(it[1:0]);
			cs32 <= lf[0];
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			lf = lfsr(lf);
			// addresses up to 0x1C reach unmapped words too
			reg_wr({3'b000, lf[4:2], 2'b00}, lf[11:8] | 4'h3 & {4{lf[12]}}, {lf, lfsr(lf)});
			reg_rd({3'b000, lf[4:2], 2'b00});
			repeat (3) @(posedge clk);
			check_pins();
		end
		// mid-run reset must clear every register
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		for (int k = 0; k < 5; k++)
			m[k] = 16'h0000;
		@(posedge clk);
		for (int a = 0; a <= 16; a += 4)
			reg_rd(a[7:0]);
		check_pins();
		test_done();
	end
endmodule : test_port_cd_pin_function_direction
`default_nettype wire
